// File: pomu_pkg.sv
/*
 * pomu_pkg: constants, types and register map shared by the pixel output merge unit
 * and its configuring controller.
 * assumes: one 50 MHz clock, synchronous active-low reset, unorm 8-bit colour channels.
 */
// Operation
// - post-blend clamp only while blending enabled
// - clamp enable set: clamp to configured range
// - blending on: always clamp to format range
// - four-bit dither from 4x4 table by position
// - add dither offsets to x and y
// - two lsbs pick column and row
// - shift dither, add, truncate to depth
// - logic op off passes pixel unchanged
// - controller never enables blend and logic together
// - logic ops only on plain unorm targets
// - sixteen bitwise functions of source, destination
// - stencil updated only if test enabled, face-selected
// - one stencil op: fail, depth-fail or pass
// - eight stencil operations incl. saturate and wrap
// - no stencil write without write enable
// - write only stencil bits set in mask
// - stencil writes only with stencil depth formats
// - stencil and depth write enables independent
// - depth written only with enable; controller clears unbound
// - failed depth test discards depth and colour
// - srgb target: gamma-encode rgb, not alpha
// - write only present, non-disabled channels
// - blending off bypasses blend and post clamp
package pomu_pkg;
	// ------------------------------------------------------------
	// register map of the controller
	// ------------------------------------------------------------
	localparam logic [7:0] POMU_REG_CTRL = 8'h00;
	localparam logic [7:0] POMU_REG_CLAMP = 8'h04;
	localparam logic [7:0] POMU_REG_DITHER = 8'h08;
	localparam logic [7:0] POMU_REG_STENCIL = 8'h0c;
	localparam logic [7:0] POMU_REG_SMASK = 8'h10;
	localparam logic [7:0] POMU_REG_SOPS = 8'h14;
	localparam logic [7:0] POMU_REG_STATUS = 8'h18;
	localparam logic [1:0] POMU_RESP_OKAY = 2'h0;
	localparam logic [1:0] POMU_RESP_SLVERR = 2'h2;
	// ctrl fields
	localparam int POMU_CTRL_BLEND = 0;
	localparam int POMU_CTRL_POSTCLAMP = 1;
	localparam int POMU_CTRL_LOGIC = 2;
	localparam int POMU_CTRL_STEST = 3;
	localparam int POMU_CTRL_DSIDED = 4;
	localparam int POMU_CTRL_SWRITE = 5;
	localparam int POMU_CTRL_DWRITE = 6;
	localparam int POMU_CTRL_DTEST = 7;
	localparam int POMU_CTRL_SRGB = 8;
	localparam int POMU_CTRL_DITHER = 9;
	localparam int POMU_CTRL_DBOUND = 10;
	localparam int POMU_CTRL_STFMT = 11;
	localparam int POMU_CTRL_UNORM = 12;
	localparam int POMU_CTRL_FUNC_LSB = 16;
	localparam int POMU_CTRL_PRESENT_LSB = 20;
	localparam int POMU_CTRL_WDIS_LSB = 24;
	localparam int POMU_CTRL_DEPTH_LSB = 28;
	localparam logic [31:0] POMU_CTRL_RESET = 32'h8000_0000;

	// ------------------------------------------------------------
	// pixel formats and operations
	// ------------------------------------------------------------
	localparam int POMU_CW = 8;
	localparam logic [7:0] POMU_CMAX = 8'hff;
	localparam logic [2:0] POMU_DEPTH_FULL = 3'h0;
	localparam logic [7:0] POMU_STENCIL_MAX = 8'hff;
	localparam logic [7:0] POMU_STENCIL_ONE = 8'h01;
	localparam logic [8:0] POMU_SUM_MAX = 9'h0ff;
	localparam logic [3:0] POMU_DITHER_TABLE [16] = '{
		4'h0, 4'h8, 4'h2, 4'ha,
		4'hc, 4'h4, 4'he, 4'h6,
		4'h3, 4'hb, 4'h1, 4'h9,
		4'hf, 4'h7, 4'hd, 4'h5};

	typedef enum logic [3:0] {
		logic_clear, logic_nor, logic_and_not_src, logic_not_src,
		logic_and_not_dst, logic_not_dst, logic_xor, logic_nand,
		logic_and, logic_xnor, logic_pass_destination, logic_or_not_src,
		logic_pass_source, logic_or_not_dst, logic_or, logic_set
	} pomu_logic_t;

	typedef enum logic [2:0] {
		stencil_keep_op, stencil_zero_op, stencil_store_reference_op,
		stencil_saturating_increment_op, stencil_saturating_decrement_op,
		stencil_wrapping_increment_op, stencil_wrapping_decrement_op, stencil_invert_op
	} pomu_sop_t;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] g;
		logic [7:0] r;
	} pomu_color_t;
endpackage

// File: pomu_if.sv
/*
 * pomu_if: joins the controller (configuration) and the merge unit (pixels).
 * assumes: both ends on aclk; pixel stream has no back-pressure.
 */
`timescale 1ns/1ps
interface pomu_if;
	import pomu_pkg::*;
	logic [31:0] ctrl;
	logic [31:0] clamp;
	logic [31:0] dither;
	logic [31:0] stencil;
	logic [31:0] smask;
	logic [31:0] sops;
	logic [31:0] pix_count;
	logic [31:0] discard_count;
	modport ctl(output ctrl, clamp, dither, stencil, smask, sops, input pix_count, discard_count);
	modport unit(input ctrl, clamp, dither, stencil, smask, sops, output pix_count, discard_count);
endinterface // pomu_if

// File: pomu_unit.sv
/*
 * pomu_unit: pixel back end: logic op, post-blend clamp, dither, gamma, stencil/depth/colour writes.
 * assumes: blended colour and test results come in on the user side one pixel per valid cycle;
 * buffer memory takes every write strobe offered.
 */
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pomu_unit
	import pomu_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	pomu_if.unit cfg,
	input wire logic in_valid,
	input wire pomu_color_t in_src,
	input wire pomu_color_t in_dst,
	input wire logic [15:0] in_x,
	input wire logic [15:0] in_y,
	input wire logic in_back,
	input wire logic in_stencil_pass,
	input wire logic in_depth_pass,
	input wire logic [7:0] in_stencil_old,
	input wire logic [31:0] in_depth,
	output logic out_color_we,
	output logic [3:0] out_color_chan,
	output pomu_color_t out_color,
	output logic out_stencil_we,
	output logic [7:0] out_stencil,
	output logic [7:0] out_stencil_mask,
	output logic out_depth_we,
	output logic [31:0] out_depth
);
	// ------------------------------------------------------------
	// configuration fields
	// ------------------------------------------------------------
	logic blend_en, post_en, logic_en, stest_en, dsided, swrite_en, dwrite_en, dtest_en, srgb, dither_en;
	logic [3:0] present, wdis;
	logic [2:0] drop_bits;
	pomu_logic_t func;
	assign blend_en = cfg.ctrl[POMU_CTRL_BLEND];
	assign post_en = cfg.ctrl[POMU_CTRL_POSTCLAMP];
	assign logic_en = cfg.ctrl[POMU_CTRL_LOGIC];
	assign stest_en = cfg.ctrl[POMU_CTRL_STEST];
	assign dsided = cfg.ctrl[POMU_CTRL_DSIDED];
	assign swrite_en = cfg.ctrl[POMU_CTRL_SWRITE];
	assign dwrite_en = cfg.ctrl[POMU_CTRL_DWRITE];
	assign dtest_en = cfg.ctrl[POMU_CTRL_DTEST];
	assign srgb = cfg.ctrl[POMU_CTRL_SRGB];
	assign dither_en = cfg.ctrl[POMU_CTRL_DITHER];
	assign func = pomu_logic_t'(cfg.ctrl[POMU_CTRL_FUNC_LSB +: 4]);
	assign present = cfg.ctrl[POMU_CTRL_PRESENT_LSB +: 4];
	assign wdis = cfg.ctrl[POMU_CTRL_WDIS_LSB +: 4];
	assign drop_bits = cfg.ctrl[POMU_CTRL_DEPTH_LSB +: 3];

	// ------------------------------------------------------------
	// colour path
	// ------------------------------------------------------------
	function automatic logic [7:0] logic_fn(input pomu_logic_t f, input logic [7:0] s, input logic [7:0] d);
		case (f)
			logic_clear: logic_fn = '0;
			logic_nor: logic_fn = ~(s | d);
			logic_and_not_src: logic_fn = ~s & d;
			logic_not_src: logic_fn = ~s;
			logic_and_not_dst: logic_fn = s & ~d;
			logic_not_dst: logic_fn = ~d;
			logic_xor: logic_fn = s ^ d;
			logic_nand: logic_fn = ~(s & d);
			logic_and: logic_fn = s & d;
			logic_xnor: logic_fn = ~(s ^ d);
			logic_pass_destination: logic_fn = d;
			logic_or_not_src: logic_fn = ~s | d;
			logic_pass_source: logic_fn = s;
			logic_or_not_dst: logic_fn = s | ~d;
			logic_or: logic_fn = s | d;
			default: logic_fn = '1;
		endcase
	endfunction

	// cheap power-curve stand-in: x^(1/2.4) approximated by the sqrt-like curve 2x-x^2/256, saturated at 255
	function automatic logic [7:0] gamma_fn(input logic [7:0] c);
		logic [15:0] sq;
		logic [8:0] up;
		sq = 16'(c) * 16'(c);
		up = {c, 1'b0} - 9'(sq[15:8]);
		gamma_fn = up[8] ? POMU_CMAX : up[7:0];
	endfunction

	logic [1:0] dcol, drow;
	logic [3:0] dval;
	assign dcol = 2'(in_x + cfg.dither[15:0]);
	assign drow = 2'(in_y + cfg.dither[31:16]);
	assign dval = POMU_DITHER_TABLE[{drow, dcol}];

	pomu_color_t next_color;
	always_comb begin
		logic [7:0] c, lo, hi;
		logic [11:0] sh;
		logic [8:0] sum;
		c = '0;
		lo = '0;
		hi = '0;
		sh = '0;
		sum = '0;
		next_color = in_src;
		for (int i = 0; i < 4; i++) begin
			c = in_src[i*8 +: 8];
			if (logic_en) begin
				c = logic_fn(func, in_src[i*8 +: 8], in_dst[i*8 +: 8]);
			end
			// blend off: bypass stays with c as given
			if (blend_en) begin
				// unorm8 carrier already saturates at format range
				lo = cfg.clamp[7:0];
				hi = cfg.clamp[15:8];
				if (post_en) begin
					if (c < lo) c = lo;
					if (c > hi) c = hi;
				end
			end
			if (dither_en) begin
				sh = {8'h00, dval} << drop_bits;
				sum = {1'b0, c} + 9'(sh[11:4]);
				if (sum > POMU_SUM_MAX) sum = POMU_SUM_MAX;
				c = sum[7:0] & (POMU_CMAX << drop_bits);
			end
			if (srgb && i < 3) begin
				c = gamma_fn(c);
			end
			next_color[i*8 +: 8] = c;
		end
	end

	// ------------------------------------------------------------
	// stencil path
	// ------------------------------------------------------------
	logic [7:0] sref, next_stencil;
	pomu_sop_t sop;
	logic use_back;
	assign use_back = dsided && in_back;
	assign sref = use_back ? cfg.stencil[15:8] : cfg.stencil[7:0];
	always_comb begin
		logic [8:0] base;
		base = use_back ? 9'(cfg.sops[17:9]) : 9'(cfg.sops[8:0]);
		if (!in_stencil_pass) sop = pomu_sop_t'(base[2:0]);
		else if (!in_depth_pass) sop = pomu_sop_t'(base[5:3]);
		else sop = pomu_sop_t'(base[8:6]);
		case (sop)
			stencil_keep_op: next_stencil = in_stencil_old;
			stencil_zero_op: next_stencil = '0;
			stencil_store_reference_op: next_stencil = sref;
			stencil_saturating_increment_op: next_stencil = (in_stencil_old == POMU_STENCIL_MAX) ? POMU_STENCIL_MAX :
				in_stencil_old + POMU_STENCIL_ONE;
			stencil_saturating_decrement_op: next_stencil = (in_stencil_old == '0) ? '0 : in_stencil_old - POMU_STENCIL_ONE;
			stencil_wrapping_increment_op: next_stencil = in_stencil_old + POMU_STENCIL_ONE;
			stencil_wrapping_decrement_op: next_stencil = in_stencil_old - POMU_STENCIL_ONE;
			default: next_stencil = ~in_stencil_old;
		endcase
	end

	logic survive;
	assign survive = !dtest_en || in_depth_pass;

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_stencil_we <= 1'b0;
			out_stencil <= '0;
			out_stencil_mask <= '0;
		end else begin
			out_stencil_we <= in_valid && stest_en && swrite_en;
			out_stencil <= next_stencil;
			out_stencil_mask <= use_back ? cfg.smask[15:8] : cfg.smask[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_depth_we <= 1'b0;
			out_depth <= '0;
		end else begin
			out_depth_we <= in_valid && dwrite_en && survive;
			out_depth <= in_depth;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_color_we <= 1'b0;
			out_color_chan <= '0;
			out_color <= '0;
		end else begin
			out_color_we <= in_valid && survive && |(present & ~wdis);
			out_color_chan <= present & ~wdis;
			out_color <= next_color;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg.pix_count <= '0;
			cfg.discard_count <= '0;
		end else if (in_valid) begin
			cfg.pix_count <= cfg.pix_count + 32'h1;
			if (!survive) cfg.discard_count <= cfg.discard_count + 32'h1;
		end
	end
endmodule // pomu_unit

// File: pomu_ctl.sv
/*
 * pomu_ctl: AXI4-Lite slave holding the merge unit configuration and reporting its counters.
 * assumes: single outstanding write and read from the master.
 */
`timescale 1ns/1ps
module pomu_ctl
	import pomu_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	pomu_if.ctl cfg
);
	// ------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] regs [6];
	logic do_write;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= POMU_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[7:2] < 6'd6) ? POMU_RESP_OKAY : POMU_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// controller must not set blend with logic, nor logic off unorm/srgb
	// stencil writes only with a stencil format, depth writes only with a bound buffer
	function automatic logic [31:0] sanitize(input logic [31:0] v);
		logic [31:0] r;
		r = v;
		if (r[POMU_CTRL_BLEND] || !r[POMU_CTRL_UNORM] || r[POMU_CTRL_SRGB]) r[POMU_CTRL_LOGIC] = 1'b0;
		if (!r[POMU_CTRL_STFMT]) r[POMU_CTRL_SWRITE] = 1'b0;
		if (!r[POMU_CTRL_DBOUND]) r[POMU_CTRL_DWRITE] = 1'b0;
		sanitize = r;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			regs[0] <= POMU_CTRL_RESET;
			for (int i = 1; i < 6; i++) regs[i] <= '0;
		end else if (do_write && aw_addr[7:2] < 6'd6) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b]) regs[aw_addr[4:2]][b*8 +: 8] <= w_data[b*8 +: 8];
			end
			if (aw_addr[4:2] == POMU_REG_CTRL[4:2]) begin
				regs[0] <= sanitize(w_data);
			end
		end
	end

	assign cfg.ctrl = regs[0];
	assign cfg.clamp = regs[1];
	assign cfg.dither = regs[2];
	assign cfg.stencil = regs[3];
	assign cfg.smask = regs[4];
	assign cfg.sops = regs[5];

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= POMU_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= POMU_RESP_OKAY;
				if (s_axi_araddr[7:2] < 6'd6) s_axi_rdata <= regs[s_axi_araddr[4:2]];
				else if (s_axi_araddr == POMU_REG_STATUS) s_axi_rdata <= cfg.pix_count;
				else if (s_axi_araddr == POMU_REG_STATUS + 8'h04) s_axi_rdata <= cfg.discard_count;
				else begin
					s_axi_rdata <= '0;
					s_axi_rresp <= POMU_RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // pomu_ctl

// File: pomu_sva.sv
/*
 * pomu_sva: assertions on the configuration carrier between the controller and the merge unit.
 * assumes: instantiated beside the carrier in the bench; ctrl is only written as whole words.
 */
`timescale 1ns/1ps
module pomu_sva
	import pomu_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] ctrl,
	input wire logic [31:0] clamp,
	input wire logic [31:0] dither,
	input wire logic [31:0] stencil,
	input wire logic [31:0] smask,
	input wire logic [31:0] sops,
	input wire logic [31:0] pix_count,
	input wire logic [31:0] discard_count
);
	// ------------------------------------------------------------
	// configuration sanity
	// ------------------------------------------------------------
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_blend_excl;
		ctrl[POMU_CTRL_BLEND] |-> !ctrl[POMU_CTRL_LOGIC];
	endproperty
	a_blend_excl: assert property (p_blend_excl) else $error("logic op on with blending");
	property p_logic_fmt;
		(ctrl[POMU_CTRL_SRGB] || !ctrl[POMU_CTRL_UNORM]) |-> !ctrl[POMU_CTRL_LOGIC];
	endproperty
	a_logic_fmt: assert property (p_logic_fmt) else $error("logic op on wrong target");
	property p_swrite_fmt;
		!ctrl[POMU_CTRL_STFMT] |-> !ctrl[POMU_CTRL_SWRITE];
	endproperty
	a_swrite_fmt: assert property (p_swrite_fmt) else $error("stencil write without stencil format");
	property p_dwrite_bound;
		!ctrl[POMU_CTRL_DBOUND] |-> !ctrl[POMU_CTRL_DWRITE];
	endproperty
	a_dwrite_bound: assert property (p_dwrite_bound) else $error("depth write with no buffer");
	// a write takes at least three edges, so ctrl must hold its reset value for two
	property p_ctrl_reset;
		$rose(aresetn) |-> (ctrl == POMU_CTRL_RESET) [*2];
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("ctrl reset value wrong");
	property p_cfg_reset;
		!$past(aresetn) |-> (clamp | dither | stencil | smask | sops) == 32'h0;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("config not cleared by reset");
	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	property p_pix_step;
		$stable(pix_count) || pix_count == $past(pix_count) + 32'h1;
	endproperty
	a_pix_step: assert property (p_pix_step) else $error("pixel count jumped");
	property p_disc_step;
		discard_count != $past(discard_count) |-> discard_count == $past(discard_count) + 32'h1;
	endproperty
	a_disc_step: assert property (p_disc_step) else $error("discard count jumped");
	property p_disc_le;
		discard_count <= pix_count;
	endproperty
	a_disc_le: assert property (p_disc_le) else $error("more discards than pixels");
	c_logic: cover property (ctrl[POMU_CTRL_LOGIC]);
	c_clamp: cover property (ctrl[POMU_CTRL_BLEND] && ctrl[POMU_CTRL_POSTCLAMP]);
	c_disc: cover property (discard_count != $past(discard_count));
endmodule // pomu_sva

// File: pixel_output_merge_update_tb.sv
/*
 * pixel_output_merge_update_tb: controller and merge unit joined by the carrier, driven over AXI4-Lite
 * and the pixel port. assumes: buffer memory side always accepts; pixel stream has no back-pressure.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module pixel_output_merge_update_tb;
	import pomu_pkg::*;
	localparam int CYCLE_LIMIT = 20000;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic in_valid = 1'b0;
	pomu_color_t in_src = '0;
	pomu_color_t in_dst = '0;
	logic [15:0] in_x = 16'h0;
	logic [15:0] in_y = 16'h0;
	logic in_back = 1'b0;
	logic in_stencil_pass = 1'b0;
	logic in_depth_pass = 1'b0;
	logic [7:0] in_stencil_old = 8'h00;
	logic [31:0] in_depth = 32'h1357_9bdf;
	logic out_color_we;
	logic [3:0] out_color_chan;
	pomu_color_t out_color;
	logic out_stencil_we;
	logic [7:0] out_stencil;
	logic [7:0] out_stencil_mask;
	logic out_depth_we;
	logic [31:0] out_depth;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_pix = 0;
	int cycles = 0;

	pomu_if cfg_if();
	pomu_ctl pomu_ctl_i(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg(cfg_if));
	pomu_unit pomu_unit_i(.aclk, .aresetn, .cfg(cfg_if), .in_valid, .in_src, .in_dst, .in_x, .in_y, .in_back,
		.in_stencil_pass, .in_depth_pass, .in_stencil_old, .in_depth, .out_color_we, .out_color_chan, .out_color,
		.out_stencil_we, .out_stencil, .out_stencil_mask, .out_depth_we, .out_depth);
	pomu_sva pomu_sva_i(.aclk, .aresetn, .ctrl(cfg_if.ctrl), .clamp(cfg_if.clamp), .dither(cfg_if.dither),
		.stencil(cfg_if.stencil), .smask(cfg_if.smask), .sops(cfg_if.sops), .pix_count(cfg_if.pix_count),
		.discard_count(cfg_if.discard_count));

	always #10 aclk = ~aclk;

	// ------------------------------------------------------------
	// bus and pixel drivers
	// ------------------------------------------------------------
	task automatic wrc(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, POMU_RESP_OKAY)
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, d)
		`CHK(s_axi_rresp, r)
	endtask

	// f is {back face, stencil pass, depth pass}; outputs are looked at in the one cycle they stand
	task automatic px(input pomu_color_t s, input pomu_color_t d, input logic [2:0] f, input logic [7:0] old);
		@(posedge aclk);
		in_valid <= 1'b1;
		in_src <= s;
		in_dst <= d;
		{in_back, in_stencil_pass, in_depth_pass} <= f;
		in_stencil_old <= old;
		@(posedge aclk);
		in_valid <= 1'b0;
		n_pix++;
		#1;
	endtask

	function automatic logic [31:0] cw(input logic [12:0] en, input logic [3:0] fn, input logic [3:0] pr,
		input logic [3:0] wd, input logic [2:0] drop);
		return POMU_CTRL_RESET | {19'h0, en} | {4'h0, wd, pr, fn, 16'h0} | {1'b0, drop, 28'h0};
	endfunction

	function automatic logic [31:0] lop(input logic [3:0] f, input logic [31:0] s, input logic [31:0] d);
		logic [31:0] t [16];
		t = '{32'h0, ~(s | d), ~s & d, ~s, s & ~d, ~d, s ^ d, ~(s & d), s & d, ~(s ^ d), d, ~s | d, s, s | ~d,
			s | d, 32'hffff_ffff};
		return t[f];
	endfunction

	function automatic logic [7:0] sop(input logic [2:0] o, input logic [7:0] v, input logic [7:0] r);
		case (o)
			3'h0: return v;
			3'h1: return 8'h00;
			3'h2: return r;
			3'h3: return (v == 8'hff) ? v : v + 8'h01;
			3'h4: return (v == 8'h00) ? v : v - 8'h01;
			3'h5: return v + 8'h01;
			3'h6: return v - 8'h01;
			default: return ~v;
		endcase
	endfunction

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rdc(POMU_REG_CTRL, POMU_CTRL_RESET, POMU_RESP_OKAY);
		rdc(8'h20, 32'h0, POMU_RESP_SLVERR);
		wrc(POMU_REG_CTRL, cw(13'h1005, 4'h3, 4'h0, 4'h0, 3'h0));
		rdc(POMU_REG_CTRL, cw(13'h1001, 4'h3, 4'h0, 4'h0, 3'h0), POMU_RESP_OKAY);
		wrc(POMU_REG_CTRL, cw(13'h1104, 4'h0, 4'h0, 4'h0, 3'h0));
		rdc(POMU_REG_CTRL, cw(13'h1100, 4'h0, 4'h0, 4'h0, 3'h0), POMU_RESP_OKAY);
		wrc(POMU_REG_CTRL, cw(13'h0060, 4'h0, 4'h0, 4'h0, 3'h0));
		rdc(POMU_REG_CTRL, cw(13'h0000, 4'h0, 4'h0, 4'h0, 3'h0), POMU_RESP_OKAY);
		$display("test regs done");
	endtask

	task automatic t_logic();
		for (int i = 0; i < 16; i++) begin
			wrc(POMU_REG_CTRL, cw(13'h1004, 4'(i), 4'hf, 4'h0, 3'h0));
			px(32'hc3a5_0ff0, 32'h5a3c_33cc, 3'b001, 8'h00);
			`CHK(out_color, lop(4'(i), 32'hc3a5_0ff0, 32'h5a3c_33cc))
		end
		wrc(POMU_REG_CTRL, cw(13'h1000, 4'h6, 4'hf, 4'h0, 3'h0));
		px(32'hc3a5_0ff0, 32'h5a3c_33cc, 3'b001, 8'h00);
		`CHK(out_color, 32'hc3a5_0ff0)
		$display("test logic done");
	endtask

	task automatic t_clamp();
		wrc(POMU_REG_CLAMP, 32'h0000_c020);
		wrc(POMU_REG_CTRL, cw(13'h0003, 4'h0, 4'hf, 4'h0, 3'h0));
		px(32'h10ff_8005, 32'h0, 3'b001, 8'h00);
		`CHK(out_color, 32'h20c0_8020)
		wrc(POMU_REG_CTRL, cw(13'h0001, 4'h0, 4'hf, 4'h0, 3'h0));
		px(32'h10ff_8005, 32'h0, 3'b001, 8'h00);
		`CHK(out_color, 32'h10ff_8005)
		wrc(POMU_REG_CTRL, cw(13'h0002, 4'h0, 4'hf, 4'h0, 3'h0));
		px(32'h10ff_8005, 32'h0, 3'b001, 8'h00);
		`CHK(out_color, 32'h10ff_8005)
		$display("test clamp done");
	endtask

	task automatic t_pixel_path();
		logic [3:0] tv;
		wrc(POMU_REG_DITHER, 32'h0003_0002);
		wrc(POMU_REG_CTRL, cw(13'h0200, 4'h0, 4'hf, 4'h0, 3'h4));
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			in_x <= 16'(i);
			in_y <= 16'(i + 1);
			px(32'h3737_3737, 32'h0, 3'b001, 8'h00);
			tv = POMU_DITHER_TABLE[{2'(i + 4), 2'(i + 2)}];
			`CHK(out_color.r, (8'h37 + {4'h0, tv}) & 8'hf0)
		end
		wrc(POMU_REG_CTRL, cw(13'h0100, 4'h0, 4'hf, 4'h0, 3'h0));
		px(32'h5a40_ff00, 32'h0, 3'b001, 8'h00);
		`CHK(out_color.a, 8'h5a)
		`CHK({out_color.r, out_color.g, out_color.b > 8'h40}, {8'h00, 8'hff, 1'b1})
		wrc(POMU_REG_CTRL, cw(13'h0000, 4'h0, 4'h3, 4'h2, 3'h0));
		px(32'h1122_3344, 32'h0, 3'b001, 8'h00);
		`CHK({out_color_we, out_color_chan}, 5'b1_0001)
		wrc(POMU_REG_CTRL, cw(13'h0000, 4'h0, 4'h4, 4'h4, 3'h0));
		px(32'h1122_3344, 32'h0, 3'b001, 8'h00);
		`CHK(out_color_we, 1'b0)
		$display("test pixel path done");
	endtask

	task automatic t_stencil_ops();
		wrc(POMU_REG_STENCIL, 32'h0000_a55a);
		wrc(POMU_REG_SMASK, 32'h0000_f0ff);
		wrc(POMU_REG_CTRL, cw(13'h0828, 4'h0, 4'hf, 4'h0, 3'h0));
		for (int i = 0; i < 16; i++) begin
			wrc(POMU_REG_SOPS, {29'h0, 3'(i >> 1)});
			px(32'h0, 32'h0, 3'b001, i[0] ? 8'hff : 8'h00);
			`CHK({out_stencil_we, out_stencil}, {1'b1, sop(3'(i >> 1), i[0] ? 8'hff : 8'h00, 8'h5a)})
		end
		$display("test stencil ops done");
	endtask

	// we is {stencil we, depth we, colour we}
	task automatic sd(input logic [12:0] en, input logic [2:0] f, input logic [7:0] old, input logic [2:0] we,
		input logic [7:0] s, input logic [7:0] m);
		wrc(POMU_REG_CTRL, cw(en, 4'h0, 4'hf, 4'h0, 3'h0));
		px(32'h1122_3344, 32'h0, f, old);
		`CHK({out_stencil_we, out_depth_we, out_color_we}, we)
		if (we[2])
			`CHK({out_stencil_mask, out_stencil & m}, {m, s & m})
		if (we[1])
			`CHK(out_depth, in_depth)
	endtask

	task automatic t_buffers();
		wrc(POMU_REG_SOPS, 32'h0002_c6b9);
		sd(13'h0ee8, 3'b011, 8'h33, 3'b111, 8'h5a, 8'hff);
		sd(13'h0ee8, 3'b010, 8'h33, 3'b100, 8'hcc, 8'hff);
		sd(13'h0ee8, 3'b000, 8'h33, 3'b100, 8'h00, 8'hff);
		sd(13'h0ee8, 3'b111, 8'h33, 3'b111, 8'h5a, 8'hff);
		sd(13'h0ef8, 3'b111, 8'hff, 3'b111, 8'h00, 8'hf0);
		sd(13'h0ef8, 3'b100, 8'hff, 3'b100, 8'hff, 8'hf0);
		sd(13'h0ef8, 3'b110, 8'h00, 3'b100, 8'h00, 8'hf0);
		sd(13'h0ea8, 3'b011, 8'h33, 3'b101, 8'h5a, 8'hff);
		sd(13'h0ec8, 3'b011, 8'h33, 3'b011, 8'h00, 8'hff);
		sd(13'h0ee0, 3'b011, 8'h33, 3'b011, 8'h00, 8'hff);
		sd(13'h0e68, 3'b010, 8'h33, 3'b111, 8'hcc, 8'hff);
		rdc(POMU_REG_STATUS, 32'(n_pix), POMU_RESP_OKAY);
		rdc(POMU_REG_STATUS + 8'h04, 32'h0000_0004, POMU_RESP_OKAY);
		$display("test buffers done");
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == CYCLE_LIMIT) begin
			n_mismatch++;
			$display("timeout after %0d cycles", cycles);
			summarize();
		end
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_logic();
		t_clamp();
		t_pixel_path();
		t_stencil_ops();
		t_buffers();
		summarize();
	end
endmodule // pixel_output_merge_update_tb
